// ===== hdl/mbcfg_regs.sv
// Modbus object map: link settings, clock, mode and memory line control
`timescale 1ns/1ns
module mbcfg_regs
  import mbcfg_pkg::*;
#(
  parameter int CYC_SEC = MBCFG_CYC_SEC
)(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire mbcfg_req_t  req_i,
  output mbcfg_ans_t       ans_o,
  input  wire logic        run_switch_i,
  input  wire logic        mem_done_i,
  output mbcfg_link_t      link_cfg_o,
  output logic             restart_o,
  output mbcfg_mode_t      mode_o,
  output logic             mem_go_o,
  output mbcfg_mreq_t      mem_op_o,
  output logic             mem_busy_o
);
  logic                   run_meta_r;
  logic                   run_r;
  logic                   rtu_pend_r;
  logic [31:0]            baud_pend_r;
  mbcfg_parity_t          par_pend_r;
  logic [7:0]             node_pend_r;
  logic                   auto_r;
  logic                   ld_time_r;
  logic                   ld_date_r;
  logic                   xfer_go_r;
  logic                   optype_r;
  logic                   psel_r;
  logic [15:0]            line_r;
  mbcfg_mode_t            mode_r;
  mbcfg_time_t            tm_r;
  mbcfg_time_t            now;
  logic                   ctl_busy;
  logic                   busy_any;
  logic [MBCFG_NBAUD-1:0] baud_hit;
  logic [15:0]            wdat;
  logic [15:0]            line_max;
  logic [17:0]            wsel;
  logic                   wr_ok;
  logic                   set_bit;
  logic [7:0]             exc_nxt;
  logic [31:0]            rd_nxt;

  // Switch is a panel pin, so it is synchronised before use
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      run_meta_r <= 1'b0;
      run_r      <= 1'b0;
    end
    else
    begin
      run_meta_r <= run_switch_i;
      run_r      <= run_meta_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < MBCFG_NBAUD; gi++)
    begin : g_baud
      assign baud_hit[gi] = req_i.data == MBCFG_BAUD_LIST[gi];
    end
  endgenerate

  assign wdat     = req_i.data[15:0];
  assign set_bit  = req_i.data[0];
  assign wsel     = {req_i.space, req_i.addr};
  assign line_max = psel_r ? MBCFG_LINE_SVC : MBCFG_LINE_MAIN;
  // A start in flight counts as busy before the sequencer leaves idle
  assign busy_any = ctl_busy || xfer_go_r;
  assign wr_ok    = req_i.valid && req_i.write && exc_nxt == MBCFG_EX_NONE;

  always_comb
  begin
    exc_nxt = MBCFG_EX_NONE;
    rd_nxt  = '0;
    case (wsel)
      {MBCFG_SP_COIL, MBCFG_A_PROTO}:
        rd_nxt[0] = rtu_pend_r;
      {MBCFG_SP_COIL, MBCFG_A_RESTART},
      {MBCFG_SP_COIL, MBCFG_A_LDTIME},
      {MBCFG_SP_COIL, MBCFG_A_LDDATE}:
        rd_nxt = '0;
      {MBCFG_SP_COIL, MBCFG_A_AUTO}:
        rd_nxt[0] = auto_r;
      {MBCFG_SP_COIL, MBCFG_A_OPTYPE}:
        rd_nxt[0] = optype_r;
      {MBCFG_SP_COIL, MBCFG_A_PSEL}:
        rd_nxt[0] = psel_r;
      {MBCFG_SP_COIL, MBCFG_A_XFER}:
      begin
        if (req_i.write && set_bit)
        begin
          if (run_r)
            exc_nxt = MBCFG_EX_FAIL;
          else if (busy_any)
            exc_nxt = MBCFG_EX_BUSY;
          else if (line_r > line_max)
            exc_nxt = MBCFG_EX_VALUE;
        end
      end
      {MBCFG_SP_DISC, MBCFG_A_BUSY}:
      begin
        rd_nxt[0] = busy_any;
        if (req_i.write)
          exc_nxt = MBCFG_EX_FUNC;
      end
      {MBCFG_SP_DISC, MBCFG_A_RUN}:
      begin
        rd_nxt[0] = run_r;
        if (req_i.write)
          exc_nxt = MBCFG_EX_FUNC;
      end
      {MBCFG_SP_HOLD, MBCFG_A_BAUD}:
      begin
        rd_nxt = baud_pend_r;
        if (req_i.write && baud_hit == '0)
          exc_nxt = MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_PARITY}:
      begin
        rd_nxt[1:0] = par_pend_r;
        if (req_i.write && wdat > MBCFG_ENUM_MAX)
          exc_nxt = MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_NODE}:
      begin
        rd_nxt[7:0] = node_pend_r;
        if (req_i.write &&
            (wdat < MBCFG_NODE_MIN || wdat > MBCFG_NODE_MAX))
          exc_nxt = MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_SEC}:
      begin
        rd_nxt[5:0] = tm_r.sec;
        if (req_i.write && (auto_r || wdat > MBCFG_SEC_MAX))
          exc_nxt = auto_r ? MBCFG_EX_FAIL : MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_MIN}:
      begin
        rd_nxt[5:0] = tm_r.min;
        if (req_i.write && (auto_r || wdat > MBCFG_SEC_MAX))
          exc_nxt = auto_r ? MBCFG_EX_FAIL : MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_HOUR}:
      begin
        rd_nxt[4:0] = tm_r.hour;
        if (req_i.write && (auto_r || wdat > MBCFG_HOUR_MAX))
          exc_nxt = auto_r ? MBCFG_EX_FAIL : MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_DAY}:
      begin
        rd_nxt[4:0] = tm_r.day;
        if (req_i.write &&
            (auto_r || wdat == 16'h0 || wdat > MBCFG_DAY_MAX))
          exc_nxt = auto_r ? MBCFG_EX_FAIL : MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_MON}:
      begin
        rd_nxt[3:0] = tm_r.mon;
        if (req_i.write &&
            (auto_r || wdat == 16'h0 || wdat > MBCFG_MON_MAX))
          exc_nxt = auto_r ? MBCFG_EX_FAIL : MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_YEAR}:
      begin
        rd_nxt[11:0] = tm_r.year;
        if (req_i.write &&
            (auto_r || wdat < MBCFG_YEAR_MIN || wdat > MBCFG_YEAR_MAX))
          exc_nxt = auto_r ? MBCFG_EX_FAIL : MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_MODE}:
      begin
        rd_nxt[1:0] = mode_r;
        if (req_i.write && run_r)
          exc_nxt = MBCFG_EX_FAIL;
        else if (req_i.write && wdat > MBCFG_ENUM_MAX)
          exc_nxt = MBCFG_EX_VALUE;
      end
      {MBCFG_SP_HOLD, MBCFG_A_LINE}:
      begin
        rd_nxt[15:0] = line_r;
        if (req_i.write && wdat > line_max)
          exc_nxt = MBCFG_EX_VALUE;
      end
      default:
        exc_nxt = MBCFG_EX_ADDR;
    endcase
  end

  // Pending link settings; the live copy only moves on restart
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rtu_pend_r  <= 1'b1;
      baud_pend_r <= MBCFG_RST_BAUD;
      par_pend_r  <= MBCFG_PAR_EVEN;
      node_pend_r <= MBCFG_RST_NODE;
    end
    else if (wr_ok)
    begin
      if (wsel == {MBCFG_SP_COIL, MBCFG_A_PROTO})
        rtu_pend_r <= set_bit;
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_BAUD})
        baud_pend_r <= req_i.data;
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_PARITY})
        par_pend_r <= mbcfg_parity_t'(wdat[1:0]);
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_NODE})
        node_pend_r <= wdat[7:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      restart_o <= 1'b0;
    else
      restart_o <= wr_ok && set_bit &&
                   wsel == {MBCFG_SP_COIL, MBCFG_A_RESTART};
  end

  // Parity loads with the other settings on restart; two stop bits are set when parity is none
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      link_cfg_o <= '{1'b1, MBCFG_RST_BAUD, MBCFG_PAR_EVEN, 1'b0,
                      MBCFG_RST_NODE};
    else if (restart_o)
    begin
      link_cfg_o.rtu      <= rtu_pend_r;
      link_cfg_o.baud     <= baud_pend_r;
      link_cfg_o.parity   <= par_pend_r;
      link_cfg_o.two_stop <= par_pend_r == MBCFG_PAR_NONE;
      link_cfg_o.node     <= node_pend_r;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      auto_r <= 1'b1;
    else if (wr_ok && wsel == {MBCFG_SP_COIL, MBCFG_A_AUTO})
      auto_r <= set_bit;
  end

  // Shadow follows the clock while auto-update is on, then freezes
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      tm_r <= '{6'h0, 6'h0, 5'h0, 5'h1, 4'h1, MBCFG_RST_YEAR};
    else if (auto_r)
      tm_r <= now;
    else if (wr_ok)
    begin
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_SEC})
        tm_r.sec <= wdat[5:0];
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_MIN})
        tm_r.min <= wdat[5:0];
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_HOUR})
        tm_r.hour <= wdat[4:0];
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_DAY})
        tm_r.day <= wdat[4:0];
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_MON})
        tm_r.mon <= wdat[3:0];
      if (wsel == {MBCFG_SP_HOLD, MBCFG_A_YEAR})
        tm_r.year <= wdat[11:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ld_time_r <= 1'b0;
      ld_date_r <= 1'b0;
    end
    else
    begin
      ld_time_r <= wr_ok && set_bit &&
                   wsel == {MBCFG_SP_COIL, MBCFG_A_LDTIME};
      ld_date_r <= wr_ok && set_bit &&
                   wsel == {MBCFG_SP_COIL, MBCFG_A_LDDATE};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      mode_r <= user_program_mode;
    else if (wr_ok && wsel == {MBCFG_SP_HOLD, MBCFG_A_MODE})
      mode_r <= mbcfg_mode_t'(wdat[1:0]);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      optype_r  <= 1'b0;
      psel_r    <= 1'b0;
      line_r    <= '0;
      xfer_go_r <= 1'b0;
    end
    else
    begin
      if (wr_ok && wsel == {MBCFG_SP_COIL, MBCFG_A_OPTYPE})
        optype_r <= set_bit;
      if (wr_ok && wsel == {MBCFG_SP_COIL, MBCFG_A_PSEL})
        psel_r <= set_bit;
      if (wr_ok && wsel == {MBCFG_SP_HOLD, MBCFG_A_LINE})
        line_r <= wdat;
      xfer_go_r <= wr_ok && set_bit &&
                   wsel == {MBCFG_SP_COIL, MBCFG_A_XFER};
    end
  end

  mbcfg_rtc #(
    .CYC_SEC   (CYC_SEC)
  ) u_rtc (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ld_time_i (ld_time_r),
    .ld_date_i (ld_date_r),
    .set_i     (tm_r),
    .now_o     (now)
  );

  mbcfg_mem_ctl u_mem (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (xfer_go_r),
    .op_i      ('{optype_r, psel_r, line_r}),
    .done_i    (mem_done_i),
    .go_o      (mem_go_o),
    .op_o      (mem_op_o),
    .busy_o    (ctl_busy)
  );

  assign mode_o     = mode_r;
  assign mem_busy_o = busy_any;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ans_o <= '0;
    else
    begin
      ans_o.valid <= req_i.valid;
      ans_o.exc   <= req_i.valid ? exc_nxt : MBCFG_EX_NONE;
      ans_o.data  <= (req_i.valid && !req_i.write) ? rd_nxt : '0;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  restart_apply_a: assert property (
    restart_o |=> link_cfg_o.baud == $past(baud_pend_r)
      && link_cfg_o.rtu == $past(rtu_pend_r))
    else $error("pending link settings not applied on restart");
  link_hold_a: assert property (
    !restart_o |=> $stable(link_cfg_o))
    else $error("link settings changed without restart");
  stop_bits_a: assert property (
    link_cfg_o.two_stop == (link_cfg_o.parity == MBCFG_PAR_NONE))
    else $error("stop bit count does not follow parity");
  node_range_a: assert property (
    node_pend_r >= MBCFG_NODE_MIN[7:0] && node_pend_r <= MBCFG_NODE_MAX[7:0])
    else $error("node address out of range");
  mode_lock_a: assert property (
    run_r |=> $stable(mode_r))
    else $error("mode changed while running");
  xfer_refuse_a: assert property (
    (req_i.valid && req_i.write && set_bit && run_r &&
     wsel == {MBCFG_SP_COIL, MBCFG_A_XFER})
      |=> ans_o.exc == MBCFG_EX_FAIL && !xfer_go_r ##1 !mem_go_o)
    else $error("memory start accepted while running");
  parity_bad_a: assert property (
    (req_i.valid && req_i.write && wdat > MBCFG_ENUM_MAX &&
     wsel == {MBCFG_SP_HOLD, MBCFG_A_PARITY})
      |=> ans_o.exc == MBCFG_EX_VALUE && $stable(par_pend_r))
    else $error("bad parity value not refused");
  busy_read_a: assert property (
    (req_i.valid && !req_i.write && wsel == {MBCFG_SP_DISC, MBCFG_A_BUSY})
      |=> ans_o.data[0] == $past(busy_any))
    else $error("busy input does not show memory state");
  time_track_a: assert property (
    auto_r |=> tm_r == $past(now))
    else $error("time registers not tracking clock");
  time_load_a: assert property (
    (ld_time_r && !auto_r) |=> now.sec == $past(tm_r.sec)
      && now.hour == $past(tm_r.hour))
    else $error("clock not loaded from time registers");
  xfer_start_a: assert property (
    xfer_go_r |=> mem_go_o ##1 !mem_go_o && mem_busy_o)
    else $error("line transfer did not start");
endmodule

// ===== hdl/mbcfg_pkg.sv
// Constants, types and behaviour notes for the Modbus config register map
// Notes on behaviour
// - Protocol coil clear means ASCII, set means RTU; applied at next restart.
// - Line speed is 32 bits, only listed rates accepted, applied at restart.
// - Parity register: 0 none, 1 odd, 2 even.
// - Eight data bits; one stop bit with parity, two stop bits without.
// - Node address register holds 1 to 247; only that address is answered.
// - Seconds, minutes, hours in three registers; 0-59, 0-59, 0-23.
// - Auto-update set keeps time registers live; clear freezes them for writes.
// - Load-time coil loads the running clock from the time registers.
// - Day 1-31 and month 1-12 registers, followed by a year register.
// - Master clears auto-update and writes date; load-date coil loads calendar.
// - Writing the restart coil set restarts and applies pending link settings.
// - Mode register: 0 user program, 1 speed service, 2 step/dir driver.
// - Mode register changes only while stopped, never while running.
// - Run switch discrete input: clear when stopped, set when running.
// - No program-memory operation is started while running.
// - Memory busy discrete input: clear when ready, set while busy.
// - Line-transfer coil starts one line read or write per operation coils.
// - Operation-type coil clear means read, set means write.
// - Program-select coil clear means main program, set means service program.
// - Line number register, range depends on the selected program.
package mbcfg_pkg;
  localparam logic [1:0]  MBCFG_SP_COIL   = 2'h0;
  localparam logic [1:0]  MBCFG_SP_DISC   = 2'h1;
  localparam logic [1:0]  MBCFG_SP_HOLD   = 2'h2;
  localparam logic [15:0] MBCFG_A_PROTO   = 16'h8100;
  localparam logic [15:0] MBCFG_A_BAUD    = 16'h8100;
  localparam logic [15:0] MBCFG_A_RESTART = 16'h8101;
  localparam logic [15:0] MBCFG_A_PARITY  = 16'h8102;
  localparam logic [15:0] MBCFG_A_NODE    = 16'h8103;
  localparam logic [15:0] MBCFG_A_SEC     = 16'h8110;
  localparam logic [15:0] MBCFG_A_AUTO    = 16'h8110;
  localparam logic [15:0] MBCFG_A_MIN     = 16'h8111;
  localparam logic [15:0] MBCFG_A_LDTIME  = 16'h8111;
  localparam logic [15:0] MBCFG_A_HOUR    = 16'h8112;
  localparam logic [15:0] MBCFG_A_LDDATE  = 16'h8112;
  localparam logic [15:0] MBCFG_A_DAY     = 16'h8113;
  localparam logic [15:0] MBCFG_A_MON     = 16'h8114;
  localparam logic [15:0] MBCFG_A_YEAR    = 16'h8115;
  localparam logic [15:0] MBCFG_A_BUSY    = 16'hf000;
  localparam logic [15:0] MBCFG_A_XFER    = 16'hf000;
  localparam logic [15:0] MBCFG_A_MODE    = 16'hf001;
  localparam logic [15:0] MBCFG_A_RUN     = 16'hf001;
  localparam logic [15:0] MBCFG_A_OPTYPE  = 16'hf005;
  localparam logic [15:0] MBCFG_A_PSEL    = 16'hf006;
  localparam logic [15:0] MBCFG_A_LINE    = 16'hf100;
  localparam logic [7:0]  MBCFG_EX_NONE   = 8'h00;
  localparam logic [7:0]  MBCFG_EX_FUNC   = 8'h01;
  localparam logic [7:0]  MBCFG_EX_ADDR   = 8'h02;
  localparam logic [7:0]  MBCFG_EX_VALUE  = 8'h03;
  localparam logic [7:0]  MBCFG_EX_FAIL   = 8'h04;
  localparam logic [7:0]  MBCFG_EX_BUSY   = 8'h06;
  localparam logic [15:0] MBCFG_SEC_MAX   = 16'h003b;
  localparam logic [15:0] MBCFG_HOUR_MAX  = 16'h0017;
  localparam logic [15:0] MBCFG_DAY_MAX   = 16'h001f;
  localparam logic [15:0] MBCFG_MON_MAX   = 16'h000c;
  localparam logic [15:0] MBCFG_YEAR_MIN  = 16'h07d0;
  localparam logic [15:0] MBCFG_YEAR_MAX  = 16'h0897;
  localparam logic [15:0] MBCFG_NODE_MIN  = 16'h0001;
  localparam logic [15:0] MBCFG_NODE_MAX  = 16'h00f7;
  localparam logic [15:0] MBCFG_ENUM_MAX  = 16'h0002;
  localparam logic [15:0] MBCFG_LINE_MAIN = 16'he969;
  localparam logic [15:0] MBCFG_LINE_SVC  = 16'h0787;
  localparam logic [11:0] MBCFG_MON30_MSK = 12'h528;
  localparam logic [3:0]  MBCFG_MON_FEB   = 4'h2;
  localparam logic [4:0]  MBCFG_DAYS_FEB  = 5'h1c;
  localparam logic [4:0]  MBCFG_DAYS_30   = 5'h1e;
  localparam logic [4:0]  MBCFG_DAYS_31   = 5'h1f;
  localparam logic [31:0] MBCFG_RST_BAUD  = 32'h0001_c200;
  localparam logic [7:0]  MBCFG_RST_NODE  = 8'h01;
  localparam logic [11:0] MBCFG_RST_YEAR  = 12'h7d0;
  localparam int          MBCFG_CLK_NS    = 4;
  localparam int          MBCFG_SEC_NS    = 1000000000;
  localparam int          MBCFG_CYC_SEC   = MBCFG_SEC_NS / MBCFG_CLK_NS;
  localparam int          MBCFG_NBAUD     = 14;
  localparam logic [31:0] MBCFG_BAUD_LIST [MBCFG_NBAUD] = '{
    32'h6e, 32'h12c, 32'h258, 32'h4b0, 32'h960, 32'h12c0, 32'h2580,
    32'h3840, 32'h4b00, 32'h9600, 32'he100, 32'h1c200, 32'h1f400,
    32'h3e800};
  typedef enum logic [1:0] {
    MBCFG_PAR_NONE = 2'h0, MBCFG_PAR_ODD = 2'h1, MBCFG_PAR_EVEN = 2'h2
  } mbcfg_parity_t;
  typedef enum logic [1:0] {
    user_program_mode = 2'h0, speed_service_mode = 2'h1,
    step_dir_driver_mode = 2'h2
  } mbcfg_mode_t;
  typedef enum logic [1:0] {
    MBCFG_MS_IDLE = 2'h0, MBCFG_MS_ISSUE = 2'h1, MBCFG_MS_WAIT = 2'h3
  } mbcfg_mstate_t;
  typedef struct packed {
    logic        valid; logic write; logic [1:0] space;
    logic [15:0] addr;  logic [31:0] data;
  } mbcfg_req_t;
  typedef struct packed {
    logic valid; logic [7:0] exc; logic [31:0] data;
  } mbcfg_ans_t;
  typedef struct packed {
    logic rtu; logic [31:0] baud; mbcfg_parity_t parity;
    logic two_stop; logic [7:0] node;
  } mbcfg_link_t;
  typedef struct packed {
    logic [5:0] sec; logic [5:0] min; logic [4:0] hour;
    logic [4:0] day; logic [3:0] mon; logic [11:0] year;
  } mbcfg_time_t;
  typedef struct packed {
    logic write; logic service; logic [15:0] line;
  } mbcfg_mreq_t;
endpackage

// ===== hdl/mbcfg_rtc.sv
// Running time-of-day and calendar counter
`timescale 1ns/1ns
module mbcfg_rtc
  import mbcfg_pkg::*;
#(
  parameter int CYC_SEC = MBCFG_CYC_SEC
)(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ld_time_i,
  input  wire logic        ld_date_i,
  input  wire mbcfg_time_t set_i,
  output mbcfg_time_t      now_o
);
  logic [31:0] pre_r;
  logic        tick;
  logic [4:0]  dmax;
  assign tick = pre_r == 32'(CYC_SEC - 1);
  // Century years are treated as leap, so 2100, inside the allowed year span, gets a 29th of February
  always_comb
  begin
    dmax = MBCFG_MON30_MSK[now_o.mon - 4'h1] ? MBCFG_DAYS_30 : MBCFG_DAYS_31;
    if (now_o.mon == MBCFG_MON_FEB)
      dmax = MBCFG_DAYS_FEB + {4'h0, now_o.year[1:0] == 2'h0};
  end
  always_ff @(posedge clk_sys_i)
    if (rst_i || tick || ld_time_i)
      pre_r <= '0;
    else
      pre_r <= pre_r + 32'h1;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      now_o <= '{6'h0, 6'h0, 5'h0, 5'h1, 4'h1, MBCFG_RST_YEAR};
    else
    begin
      if (tick)
      begin
        now_o.sec <= now_o.sec + 6'h1;
        if (now_o.sec == MBCFG_SEC_MAX[5:0])
        begin
          now_o.sec <= '0;
          now_o.min <= now_o.min + 6'h1;
          if (now_o.min == MBCFG_SEC_MAX[5:0])
          begin
            now_o.min  <= '0;
            now_o.hour <= now_o.hour + 5'h1;
            if (now_o.hour == MBCFG_HOUR_MAX[4:0])
            begin
              now_o.hour <= '0;
              now_o.day  <= now_o.day + 5'h1;
              if (now_o.day >= dmax)
              begin
                now_o.day <= 5'h1;
                now_o.mon <= now_o.mon + 4'h1;
                if (now_o.mon == MBCFG_MON_MAX[3:0])
                begin
                  now_o.mon  <= 4'h1;
                  now_o.year <= now_o.year + 12'h1;
                end
              end
            end
          end
        end
      end
      if (ld_time_i)
      begin
        now_o.sec  <= set_i.sec;
        now_o.min  <= set_i.min;
        now_o.hour <= set_i.hour;
      end
      if (ld_date_i)
      begin
        now_o.day  <= set_i.day;
        now_o.mon  <= set_i.mon;
        now_o.year <= set_i.year;
      end
    end
  end
endmodule

// ===== hdl/mbcfg_mem_ctl.sv
// Single-line program memory transfer sequencer
`timescale 1ns/1ns
module mbcfg_mem_ctl
  import mbcfg_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire mbcfg_mreq_t op_i,
  input  wire logic        done_i,
  output logic             go_o,
  output mbcfg_mreq_t      op_o,
  output logic             busy_o
);
  mbcfg_mstate_t st_r;
  always_ff @(posedge clk_sys_i)
    if (rst_i)
      st_r <= MBCFG_MS_IDLE;
    else
      case (st_r)
        MBCFG_MS_IDLE:  if (start_i) st_r <= MBCFG_MS_ISSUE;
        MBCFG_MS_ISSUE: st_r <= MBCFG_MS_WAIT;
        MBCFG_MS_WAIT:  if (done_i) st_r <= MBCFG_MS_IDLE;
        default:        st_r <= MBCFG_MS_IDLE;
      endcase
  // Operation is frozen at start so later coil writes cannot alter it
  always_ff @(posedge clk_sys_i)
    if (rst_i)
      op_o <= '0;
    else if (start_i && st_r == MBCFG_MS_IDLE)
      op_o <= op_i;
  assign go_o   = st_r == MBCFG_MS_ISSUE;
  assign busy_o = st_r != MBCFG_MS_IDLE;
endmodule

// ===== tb/mbcfg_master.sv
// Behavioural Modbus master: one object access per call
`timescale 1ns/1ns
module mbcfg_master
  import mbcfg_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire mbcfg_ans_t ans_i,
  output mbcfg_req_t      req_o
);
  initial req_o = '0;
  task automatic xact(input logic wr, input logic [1:0] sp,
                      input logic [15:0] a, input logic [31:0] d,
                      output logic [7:0] exc, output logic [31:0] rd);
    @(posedge clk_sys_i);
    #1 req_o = '{1'b1, wr, sp, a, d};
    @(posedge clk_sys_i);
    #1 exc = ans_i.valid ? ans_i.exc : 8'hff;
    rd = ans_i.data;
    // Released lines invert so a stale request never looks valid
    req_o = '{1'b0, ~wr, ~sp, ~a, ~d};
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the Modbus configuration register map
`timescale 1ns/1ns
module tb_top;
  import mbcfg_pkg::*;
  localparam logic [1:0] C = MBCFG_SP_COIL, D = MBCFG_SP_DISC;
  localparam logic [1:0] H = MBCFG_SP_HOLD;
  localparam logic [7:0] OK = MBCFG_EX_NONE, BV = MBCFG_EX_VALUE;
  localparam logic [7:0] RF = MBCFG_EX_FAIL;
  logic        clk_sys_i, rst_i, run_i, done_i, rst_p, go, busy;
  mbcfg_req_t  req;
  mbcfg_ans_t  ans;
  mbcfg_link_t link;
  mbcfg_mode_t mode;
  mbcfg_mreq_t mop;
  logic [7:0]  ex;
  logic [31:0] rd;
  int          errors = 0;
  int          cmp_count = 0;
  mbcfg_regs #(.CYC_SEC(10)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .req_i(req), .ans_o(ans), .run_switch_i(run_i), .mem_done_i(done_i),
    .link_cfg_o(link), .restart_o(rst_p), .mode_o(mode), .mem_go_o(go),
    .mem_op_o(mop), .mem_busy_o(busy));
  mbcfg_master m (.clk_sys_i(clk_sys_i), .ans_i(ans), .req_o(req));
  task automatic chk(string n, logic [47:0] e, logic [47:0] s);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [1:0] s, logic [15:0] a, logic [31:0] d,
                    logic [7:0] e);
    m.xact(1'b1, s, a, d, ex, rd);
    chk($sformatf("exc %h", a), e, ex);
  endtask
  task automatic rdc(logic [1:0] s, logic [15:0] a, logic [31:0] e);
    m.xact(1'b0, s, a, 32'h0, ex, rd);
    chk($sformatf("data %h", a), {OK, e}, {ex, rd});
  endtask
  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_link();
    rdc(H, MBCFG_A_BAUD, 32'h1c200);
    wr(H, MBCFG_A_BAUD, 32'h3e800, OK);
    wr(H, MBCFG_A_BAUD, 32'h3e801, BV);
    wr(H, MBCFG_A_PARITY, 32'h3, BV);
    wr(H, MBCFG_A_PARITY, 32'h1, OK);
    wr(H, MBCFG_A_PARITY, 32'h0, OK);
    wr(H, MBCFG_A_NODE, 32'hf8, BV);
    wr(H, MBCFG_A_NODE, 32'hf7, OK);
    wr(C, MBCFG_A_PROTO, 32'h0, OK);
    chk("link held", 48'h1c200, link.baud);
    wr(C, MBCFG_A_RESTART, 32'h1, OK);
    chk("restart", 1, rst_p);
    @(posedge clk_sys_i);
    #1 chk("link", {1'b0, 32'h3e800, MBCFG_PAR_NONE, 1'b1, 8'hf7},
      link);
  endtask
  task automatic t_clock();
    wr(H, MBCFG_A_SEC, 32'h5, RF);
    wr(C, MBCFG_A_AUTO, 32'h0, OK);
    wr(H, MBCFG_A_SEC, 32'h3c, BV);
    wr(H, MBCFG_A_MIN, 32'h3c, BV);
    wr(H, MBCFG_A_HOUR, 32'h18, BV);
    wr(H, MBCFG_A_HOUR, 32'h17, OK);
    wr(H, MBCFG_A_DAY, 32'h0, BV);
    wr(H, MBCFG_A_MON, 32'hd, BV);
    wr(H, MBCFG_A_MON, 32'hc, OK);
    wr(C, MBCFG_A_LDTIME, 32'h1, OK);
    wr(C, MBCFG_A_LDDATE, 32'h1, OK);
    wr(C, MBCFG_A_AUTO, 32'h1, OK);
    rdc(H, MBCFG_A_HOUR, 32'h17);
    rdc(H, MBCFG_A_MON, 32'hc);
  endtask
  task automatic t_mode();
    wr(H, MBCFG_A_MODE, 32'h3, BV);
    for (int i = 0; i < 3; i++)
    begin
      wr(H, MBCFG_A_MODE, i, OK);
      @(posedge clk_sys_i);
      #1 chk("mode", i, mode);
    end
    run_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rdc(D, MBCFG_A_RUN, 32'h1);
    wr(H, MBCFG_A_MODE, 32'h0, RF);
    wr(C, MBCFG_A_XFER, 32'h1, RF);
    chk("mode run", {step_dir_driver_mode, 1'b0}, {mode, busy});
    wr(D, MBCFG_A_RUN, 32'h0, MBCFG_EX_FUNC);
    run_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rdc(D, MBCFG_A_RUN, 32'h0);
  endtask
  task automatic t_mem();
    wr(C, MBCFG_A_OPTYPE, 32'h1, OK);
    wr(C, MBCFG_A_PSEL, 32'h1, OK);
    wr(H, MBCFG_A_LINE, 32'h788, BV);
    wr(H, MBCFG_A_LINE, 32'h787, OK);
    wr(C, MBCFG_A_XFER, 32'h1, OK);
    chk("busy", 1, busy);
    @(posedge clk_sys_i);
    #1 chk("go op", {1'b1, 18'h30787}, {go, mop});
    wr(C, MBCFG_A_XFER, 32'h1, MBCFG_EX_BUSY);
    rdc(D, MBCFG_A_BUSY, 32'h1);
    done_i = 1'b1;
    @(posedge clk_sys_i);
    #1 done_i = 1'b0;
    // Bounded wait for the sequencer to go idle
    for (int i = 0; i < 8 && busy !== 1'b0; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    if (busy !== 1'b0)
    begin
      chk("busy timeout", 0, busy);
      conclude();
    end
    rdc(D, MBCFG_A_BUSY, 32'h0);
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    rst_i = 1'b1;
    run_i = 1'b0;
    done_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    t_link();
    t_clock();
    t_mode();
    t_mem();
    conclude();
  end
endmodule
